//--- rtl/dcac_top.sv
// Summary of operation
// - Writing restart bit resets engine, self-clears.
// - Block enable gates all channels, resets zero.
// - Channel runs only with both enables set.
// - Debug register returns last completed packet's data.
// - Pointer advances by packet size each packet.
// - Memory side is the transfer's bus slave.
// - Pointer equal end stops, sets done flag.
// - End limit applies only with increment enabled.
// - Memory address fields are 24 bits, upper reserved.
// - Each channel has its own register set.
// - Done and error bits masked, ORed together.
// - Pointer static when increment is off.
`timescale 1ns/100ps
`include "dcac_map.svh"
module dcac_top import dcac_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Packet completion from the memory-side transfer, one pulse per packet
  input wire logic [`DCAC_NUM_CH-1:0] pkt_done,
  input wire logic [`DCAC_NUM_CH-1:0] pkt_err,
  input wire logic [31:0] pkt_data,
  // Memory slave address per channel and run status
  output logic [`DCAC_NUM_CH*`DCAC_ADDR_W-1:0] mem_addr,
  output logic [`DCAC_NUM_CH-1:0] ch_run,
  output logic [`DCAC_NUM_CH-1:0] ch_term,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    dcac_bus_t bus;
    logic act;
    logic srst;
    logic [31:0] pkt;
    logic [`DCAC_NUM_CH-1:0] gstat;
    logic [`DCAC_NUM_CH-1:0] gmask;
    logic [`DCAC_NUM_CH-1:0] pend;
    logic rd_pend;
    logic rd_ch;
    logic [0:0] rd_idx;
    logic [0:0] eng_idx;
    logic [`DCAC_NUM_CH*`DCAC_ADDR_W-1:0] addr_o;
    logic [`DCAC_NUM_CH-1:0] run_o;
    logic [`DCAC_NUM_CH-1:0] term_o;
    logic irq_o;
  } dcac_state_t;

  dcac_state_t s_q, s_d;
  dcac_ch_t ch_all [`DCAC_NUM_CH];
  dcac_ch_t ch_rd;
  logic ch_we;
  logic [0:0] ch_widx;
  dcac_ch_t ch_wd;

  // Decodes a byte address into channel hit, index and in-channel offset.
  function automatic logic ch_hit(input logic [11:0] a);
    ch_hit = a >= `DCAC_CH_BASE && a < `DCAC_CH_BASE + 12'(`DCAC_NUM_CH) * `DCAC_CH_STRIDE;
  endfunction : ch_hit
  function automatic logic [0:0] ch_idx(input logic [11:0] a);
    logic [11:0] r;
    r = (a - `DCAC_CH_BASE) / `DCAC_CH_STRIDE;
    ch_idx = r[0:0];
  endfunction : ch_idx
  function automatic logic [4:0] ch_off(input logic [11:0] a);
    logic [11:0] r;
    r = (a - `DCAC_CH_BASE) % `DCAC_CH_STRIDE;
    ch_off = r[4:0];
  endfunction : ch_off
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] b);
    for (int k = 0; k < 4; k++) begin
      merge[k*8 +: 8] = b[k] ? n[k*8 +: 8] : o[k*8 +: 8];
    end
  endfunction : merge

  dcac_ch_regs u_regs (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clr(s_q.srst),
    .we(ch_we),
    .widx(ch_widx),
    .wdata(ch_wd),
    .ridx(s_d.rd_idx),
    .rdata(ch_rd),
    .all_q(ch_all)
  );

  always_comb begin
    dcac_ch_t c;
    logic [31:0] v;
    logic [4:0] off;
    logic [`DCAC_ADDR_W-1:0] step;
    logic run;
    logic inc;
    int i;
    dcac_state_t keep;
    keep = '0;
    c = '0;
    v = '0;
    off = '0;
    step = '0;
    run = 1'b0;
    inc = 1'b0;
    i = 0;
    s_d = s_q;
    ch_we = 1'b0;
    ch_widx = '0;
    ch_wd = '0;
    s_d.srst = 1'b0;

    // Engine: one channel serviced per cycle, round robin through the write port.
    s_d.eng_idx = s_q.eng_idx + 1'b1;
    i = int'(s_q.eng_idx);
    c = ch_all[i];
    run = s_q.act && c.en;
    inc = c.ctrl[`DCAC_BIT_INC_MEM];
    step = `DCAC_ADDR_W'(c.ctrl[`DCAC_SIZE_LSB +: `DCAC_SIZE_W]);
    if (!run) begin
      c.st = DCAC_CH_IDLE;
    end else begin
      case (c.st)
        DCAC_CH_IDLE: begin
          c.st = DCAC_CH_RUN;
        end
        DCAC_CH_RUN: begin
          if (inc && c.mem_ptr == c.mem_end) begin
            c.st = DCAC_CH_DONE;
            c.istat[`DCAC_ST_DONE] = 1'b1;
          end
        end
        default: begin
          c.st = DCAC_CH_DONE;
        end
      endcase
    end
    s_d.run_o[i] = run && c.st == DCAC_CH_RUN;
    s_d.term_o[i] = c.st == DCAC_CH_DONE;
    s_d.addr_o[i*`DCAC_ADDR_W +: `DCAC_ADDR_W] = c.mem_ptr;
    // The channel not serviced this cycle must stop too, not one lap later.
    if (!s_q.act) begin
      s_d.run_o = '0;
    end
    ch_we = 1'b1;
    ch_widx = s_q.eng_idx;

    // Bus slave.
    if (s_awready && s_awvalid) begin
      s_d.bus.aw_got = 1'b1;
      s_d.bus.awaddr = s_awaddr;
    end
    if (s_wready && s_wvalid) begin
      s_d.bus.w_got = 1'b1;
      s_d.bus.wdata = s_wdata;
      s_d.bus.wstrb = s_wstrb;
    end
    if (s_q.bus.bvalid && s_bready) begin
      s_d.bus.bvalid = 1'b0;
    end
    if (s_q.bus.aw_got && s_q.bus.w_got && !s_q.bus.bvalid) begin
      s_d.bus.aw_got = 1'b0;
      s_d.bus.w_got = 1'b0;
      s_d.bus.bvalid = 1'b1;
      s_d.bus.bresp = `DCAC_RESP_OK;
      if (s_q.bus.awaddr == `DCAC_OFF_MAIN_CTRL) begin
        if (s_q.bus.wstrb[0]) begin
          s_d.act = s_q.bus.wdata[`DCAC_BIT_ACT];
          s_d.srst = s_q.bus.wdata[`DCAC_BIT_SRST];
        end
      end else if (s_q.bus.awaddr == `DCAC_OFF_PKT_DBG) begin
        s_d.bus.bresp = `DCAC_RESP_ERR;
      end else if (s_q.bus.awaddr == `DCAC_OFF_IRQ_MASK) begin
        v = merge(32'(s_q.gmask), s_q.bus.wdata, s_q.bus.wstrb);
        s_d.gmask = v[`DCAC_NUM_CH-1:0];
      end else if (s_q.bus.awaddr == `DCAC_OFF_IRQ_STAT) begin
        s_d.bus.bresp = `DCAC_RESP_OK;
      end else if (ch_hit(s_q.bus.awaddr)) begin
        // A register write on either channel takes the port this cycle;
        // the engine update for the serviced channel is simply retried next lap.
        off = ch_off(s_q.bus.awaddr);
        ch_widx = ch_idx(s_q.bus.awaddr);
        c = ch_all[int'(ch_widx)];
        if (off == `DCAC_CH_EN) begin
          v = merge(32'(c.en), s_q.bus.wdata, s_q.bus.wstrb);
          c.en = v[0];
        end else if (off == `DCAC_CH_MEM_START) begin
          v = merge(32'(c.mem_ptr), s_q.bus.wdata, s_q.bus.wstrb);
          c.mem_ptr = v[`DCAC_ADDR_W-1:0];
          c.st = DCAC_CH_IDLE;
        end else if (off == `DCAC_CH_MEM_END) begin
          v = merge(32'(c.mem_end), s_q.bus.wdata, s_q.bus.wstrb);
          c.mem_end = v[`DCAC_ADDR_W-1:0];
        end else if (off == `DCAC_CH_DEV_ADDR) begin
          c.dev_addr = merge(c.dev_addr, s_q.bus.wdata, s_q.bus.wstrb);
        end else if (off == `DCAC_CH_CTRL) begin
          c.ctrl = merge(c.ctrl, s_q.bus.wdata, s_q.bus.wstrb);
        end else if (off == `DCAC_CH_ISTAT) begin
          v = merge(32'(c.istat), s_q.bus.wdata, s_q.bus.wstrb);
          c.istat = c.istat & ~v[`DCAC_ISTAT_W-1:0];
        end else if (off == `DCAC_CH_IEN) begin
          v = merge(32'(c.ien), s_q.bus.wdata, s_q.bus.wstrb);
          c.ien = v[`DCAC_ISTAT_W-1:0];
        end else begin
          s_d.bus.bresp = `DCAC_RESP_ERR;
        end
      end else begin
        s_d.bus.bresp = `DCAC_RESP_ERR;
      end
    end

    // Packet completions update the pointer even under a register write, unless that write reloads the start pointer.
    // A completion for a channel not serviced this cycle waits here, so none is lost.
    for (int k = 0; k < `DCAC_NUM_CH; k++) begin
      if (pkt_done[k] && s_q.act) begin
        s_d.pkt = pkt_data;
        s_d.pend[k] = 1'b1;
      end
    end
    s_d.pend[int'(ch_widx)] = 1'b0;
    if (!s_q.act) begin
      s_d.pend = '0;
    end
    if ((s_q.pend[int'(ch_widx)] || pkt_done[int'(ch_widx)]) && s_q.act && c.en &&
        c.st == DCAC_CH_RUN) begin
      if (c.ctrl[`DCAC_BIT_INC_MEM]) begin
        c.mem_ptr = c.mem_ptr +
          `DCAC_ADDR_W'(c.ctrl[`DCAC_SIZE_LSB +: `DCAC_SIZE_W]);
      end
    end
    if (pkt_err[int'(ch_widx)]) begin
      c.istat[`DCAC_ST_ERR] = 1'b1;
    end
    ch_wd = c;

    // Channel events are ORed after per-bit enables, then latched globally.
    for (int k = 0; k < `DCAC_NUM_CH; k++) begin
      if (|(ch_all[k].istat & ch_all[k].ien)) begin
        s_d.gstat[k] = 1'b1;
      end
    end

    // Read channel.
    if (s_q.bus.rvalid && s_rready) begin
      s_d.bus.rvalid = 1'b0;
    end
    if (s_q.rd_pend) begin
      s_d.rd_pend = 1'b0;
      s_d.bus.rvalid = 1'b1;
      s_d.bus.rdata = '0;
      if (s_q.rd_ch) begin
        off = s_q.bus.rdata[4:0];
        if (off == `DCAC_CH_EN) begin
          s_d.bus.rdata = 32'(ch_rd.en);
        end else if (off == `DCAC_CH_MEM_START) begin
          s_d.bus.rdata = 32'(ch_rd.mem_ptr);
        end else if (off == `DCAC_CH_MEM_END) begin
          s_d.bus.rdata = 32'(ch_rd.mem_end);
        end else if (off == `DCAC_CH_DEV_ADDR) begin
          s_d.bus.rdata = ch_rd.dev_addr;
        end else if (off == `DCAC_CH_CTRL) begin
          s_d.bus.rdata = ch_rd.ctrl;
        end else if (off == `DCAC_CH_ISTAT) begin
          s_d.bus.rdata = 32'(ch_rd.istat);
        end else begin
          s_d.bus.rdata = 32'(ch_rd.ien);
        end
      end
    end else if (s_arready && s_arvalid) begin
      s_d.bus.rresp = `DCAC_RESP_OK;
      s_d.bus.rdata = '0;
      if (s_araddr == `DCAC_OFF_MAIN_CTRL) begin
        s_d.bus.rvalid = 1'b1;
        s_d.bus.rdata = 32'(s_q.act);
      end else if (s_araddr == `DCAC_OFF_PKT_DBG) begin
        s_d.bus.rvalid = 1'b1;
        s_d.bus.rdata = s_q.pkt;
      end else if (s_araddr == `DCAC_OFF_IRQ_STAT) begin
        s_d.bus.rvalid = 1'b1;
        s_d.bus.rdata = 32'(s_q.gstat);
        s_d.gstat = '0;
        for (int k = 0; k < `DCAC_NUM_CH; k++) begin
          if (|(ch_all[k].istat & ch_all[k].ien)) begin
            s_d.gstat[k] = 1'b1;
          end
        end
      end else if (s_araddr == `DCAC_OFF_IRQ_MASK) begin
        s_d.bus.rvalid = 1'b1;
        s_d.bus.rdata = 32'(s_q.gmask);
      end else if (ch_hit(s_araddr) && ch_off(s_araddr) <= `DCAC_CH_IEN &&
                   s_araddr[1:0] == 2'b00) begin
        s_d.rd_pend = 1'b1;
        s_d.rd_ch = 1'b1;
        s_d.rd_idx = ch_idx(s_araddr);
        s_d.bus.rdata = 32'(ch_off(s_araddr));
      end else begin
        s_d.bus.rvalid = 1'b1;
        s_d.bus.rresp = `DCAC_RESP_ERR;
      end
    end

    s_d.irq_o = |(s_d.gstat & s_d.gmask);
    // Bus handshakes survive the soft reset so the write that caused it still answers.
    if (s_q.srst) begin
      keep = s_d;
      s_d = '0;
      s_d.bus = keep.bus;
      s_d.rd_pend = keep.rd_pend;
      s_d.rd_ch = keep.rd_ch;
      s_d.rd_idx = keep.rd_idx;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_awready = !s_q.bus.aw_got && !s_q.srst;
  assign s_wready = !s_q.bus.w_got && !s_q.srst;
  assign s_bvalid = s_q.bus.bvalid;
  assign s_bresp = s_q.bus.bresp;
  assign s_arready = !s_q.bus.rvalid && !s_q.rd_pend;
  assign s_rvalid = s_q.bus.rvalid;
  assign s_rdata = s_q.bus.rdata;
  assign s_rresp = s_q.bus.rresp;
  assign mem_addr = s_q.addr_o;
  assign ch_run = s_q.run_o;
  assign ch_term = s_q.term_o;
  assign irq = s_q.irq_o;

  srst_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_q.srst |=> !s_q.srst && !s_q.act) else $error("soft reset did not clear");
  act_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !s_q.act |=> ch_run == '0) else $error("channel runs while block disabled");
  ch_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ch_run[0] |-> $past(ch_all[0].en)) else $error("channel runs while disabled");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    irq |-> $past(|(s_d.gstat & s_d.gmask))) else $error("irq without cause");
  rd_answer_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_arvalid && s_arready) |-> ##[1:2] s_rvalid) else $error("read not answered");
  wr_answer_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_q.bus.aw_got && s_q.bus.w_got && !s_bvalid) |=> s_bvalid)
    else $error("write not answered");
  ptr_width_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (s_rvalid && $past(s_q.rd_ch && s_q.rd_pend) && $past(s_q.bus.rdata[4:0]) ==
     `DCAC_CH_MEM_START) |-> s_rdata[31:24] == 8'h00)
    else $error("reserved pointer bits set");
  pkt_dbg_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (pkt_done[0] && s_q.act && !s_q.srst) |=> s_q.pkt == $past(pkt_data))
    else $error("debug word not captured");
endmodule : dcac_top

//--- rtl/dcac_map.svh
`ifndef DCAC_MAP_SVH
`define DCAC_MAP_SVH
`define DCAC_NUM_CH 2
`define DCAC_ADDR_W 24
`define DCAC_OFF_MAIN_CTRL 12'h000
`define DCAC_OFF_PKT_DBG 12'h004
`define DCAC_OFF_IRQ_STAT 12'h008
`define DCAC_OFF_IRQ_MASK 12'h00c
`define DCAC_CH_BASE 12'h010
`define DCAC_CH_STRIDE 12'h020
`define DCAC_CH_EN 5'h00
`define DCAC_CH_MEM_START 5'h04
`define DCAC_CH_MEM_END 5'h08
`define DCAC_CH_DEV_ADDR 5'h0c
`define DCAC_CH_CTRL 5'h10
`define DCAC_CH_ISTAT 5'h14
`define DCAC_CH_IEN 5'h18
`define DCAC_BIT_ACT 0
`define DCAC_BIT_SRST 1
`define DCAC_BIT_INC_MEM 16
`define DCAC_SIZE_LSB 20
`define DCAC_SIZE_W 3
`define DCAC_ST_DONE 0
`define DCAC_ST_ERR 1
`define DCAC_ISTAT_W 2
`define DCAC_RESP_OK 2'b00
`define DCAC_RESP_ERR 2'b10
`endif

//--- rtl/dcac_pkg.sv
package dcac_pkg;
  typedef enum logic [1:0] {
    DCAC_CH_IDLE = 2'b00,
    DCAC_CH_RUN = 2'b01,
    DCAC_CH_DONE = 2'b10
  } dcac_ch_state_t;

  typedef struct packed {
    logic en;
    logic [23:0] mem_ptr;
    logic [23:0] mem_end;
    logic [31:0] dev_addr;
    logic [31:0] ctrl;
    logic [1:0] istat;
    logic [1:0] ien;
    dcac_ch_state_t st;
  } dcac_ch_t;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic error;
  } dcac_pkt_t;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dcac_bus_t;
endpackage : dcac_pkg

//--- rtl/dcac_ch_regs.sv
`timescale 1ns/100ps
`include "dcac_map.svh"
// Per-channel state registers; read data is registered one cycle after the index.
module dcac_ch_regs import dcac_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Soft reset clears every channel at once.
  input wire logic clr,
  // Write port
  input wire logic we,
  input wire logic [0:0] widx,
  input wire dcac_ch_t wdata,
  // Read port
  input wire logic [0:0] ridx,
  output dcac_ch_t rdata,
  // Full view for the engine
  output dcac_ch_t all_q [`DCAC_NUM_CH]
);
  dcac_ch_t mem_q [`DCAC_NUM_CH];
  dcac_ch_t rd_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_q <= '0;
    end else begin
      rd_q <= mem_q[ridx];
    end
  end
  for (genvar i = 0; i < `DCAC_NUM_CH; i++) begin : g_ch
    always_ff @(posedge clk_sys) begin
      if (!resetn) begin
        mem_q[i] <= '0;
      end else if (clr) begin
        mem_q[i] <= '0;
      end else if (we && widx == i[0:0]) begin
        mem_q[i] <= wdata;
      end
    end
    assign all_q[i] = mem_q[i];
  end
  assign rdata = rd_q;
endmodule : dcac_ch_regs

//--- tb/dcac_xfer_model.sv
`timescale 1ns/100ps
// Peripheral master on the far side: moves one packet at a time, alternating fast and slow.
module dcac_xfer_model import dcac_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Requests from the bench and channel status from the engine
  input wire logic [1:0] want,
  input wire logic [1:0] ch_run,
  // Packet completion towards the engine
  output logic [1:0] pkt_done,
  output logic [1:0] pkt_err,
  output logic [31:0] pkt_data,
  // Word of the last packet, for the bench's expectations
  output logic [31:0] last_word
);
  logic [3:0] gap_q;
  logic [7:0] seq_q;
  logic rr_q;

  always_ff @(posedge clk_sys) begin
    pkt_done <= 2'h0;
    pkt_err <= 2'h0;
    if (!resetn) begin
      gap_q <= 4'h3;
      seq_q <= 8'h00;
      rr_q <= 1'b0;
      pkt_data <= 32'h0;
      last_word <= 32'h0;
    end else begin
      // A released data bus must not keep the last word, so it shows the inverse.
      pkt_data <= ~last_word;
      rr_q <= ~rr_q;
      if (gap_q != 4'h0) begin
        gap_q <= gap_q - 4'h1;
      end else if (want[rr_q] && ch_run[rr_q]) begin
        pkt_done[rr_q] <= 1'b1;
        pkt_data <= {8'ha5, seq_q, 8'h3c, ~seq_q};
        last_word <= {8'ha5, seq_q, 8'h3c, ~seq_q};
        seq_q <= seq_q + 8'h01;
        gap_q <= seq_q[0] ? 4'h9 : 4'h3;
      end
    end
  end
endmodule : dcac_xfer_model

//--- tb/dcac_top_tb.sv
`timescale 1ns/100ps
`include "dcac_map.svh"
module dcac_top_tb;
  import dcac_pkg::*;
  `define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %0t %s got %h exp %h", $time, msg, got, exp); end end

  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [1:0] s_bresp, s_rresp, rresp, want = 2'h0, pkt_done, pkt_err, ch_run, ch_term;
  logic [31:0] s_rdata, pkt_data, last_word, rd;
  logic [47:0] mem_addr;
  int error_cnt = 0;
  int n_tests = 0;
  int sizes [3] = '{1, 2, 4};

  always #5 clk_sys = ~clk_sys;

  dcac_top dut (.clk_sys(clk_sys), .resetn(resetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .pkt_done(pkt_done), .pkt_err(pkt_err), .pkt_data(pkt_data), .mem_addr(mem_addr),
    .ch_run(ch_run), .ch_term(ch_term), .irq(irq));

  dcac_xfer_model model (.clk_sys(clk_sys), .resetn(resetn), .want(want), .ch_run(ch_run),
    .pkt_done(pkt_done), .pkt_err(pkt_err), .pkt_data(pkt_data), .last_word(last_word));

  function automatic logic [11:0] ch_a(input int ch, input logic [4:0] off);
    return `DCAC_CH_BASE + 12'(ch) * `DCAC_CH_STRIDE + {7'h0, off};
  endfunction : ch_a

  task automatic finish_test();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic aw_hs, w_hs, b_hs;
    logic [1:0] resp;
    n = 0;
    aw_hs = 1'b0;
    w_hs = 1'b0;
    b_hs = 1'b0;
    resp = 2'h0;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (n < 200) begin
      // Sample mid-cycle where the slave's outputs are settled, then act on the edge.
      @(negedge clk_sys);
      aw_hs = s_awvalid && s_awready;
      w_hs = s_wvalid && s_wready;
      b_hs = s_bvalid;
      resp = s_bresp;
      @(posedge clk_sys);
      n++;
      if (aw_hs) s_awvalid <= 1'b0;
      if (w_hs) s_wvalid <= 1'b0;
      if (b_hs) begin
        `CHK(resp, `DCAC_RESP_OK, "write response")
        s_bready <= 1'b0;
        break;
      end
    end
    if (n >= 200) `CHK(1'b0, 1'b1, "write timeout")
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_hs, r_hs;
    n = 0;
    ar_hs = 1'b0;
    r_hs = 1'b0;
    d = 32'hx;
    r = 2'hx;
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (n < 200) begin
      @(negedge clk_sys);
      ar_hs = s_arvalid && s_arready;
      r_hs = s_rvalid;
      if (r_hs) begin
        d = s_rdata;
        r = s_rresp;
      end
      @(posedge clk_sys);
      n++;
      if (ar_hs) s_arvalid <= 1'b0;
      if (r_hs) begin
        s_rready <= 1'b0;
        break;
      end
    end
    if (n >= 200) `CHK(1'b0, 1'b1, "read timeout")
  endtask : axi_rd

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rresp);
    `CHK(rresp, `DCAC_RESP_OK, "read response")
    `CHK(rd, exp, "read data")
  endtask : rd_chk

  task automatic wait_term(input int ch);
    int n;
    for (n = 0; n < 400 && ch_term[ch] !== 1'b1; n++) @(posedge clk_sys);
    if (n >= 400) `CHK(1'b0, 1'b1, "no termination")
  endtask : wait_term

  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd_chk(`DCAC_OFF_MAIN_CTRL, 32'h0);
    rd_chk(`DCAC_OFF_PKT_DBG, 32'h0);
    rd_chk(ch_a(0, `DCAC_CH_MEM_START), 32'h0);
    rd_chk(ch_a(1, `DCAC_CH_MEM_END), 32'h0);
    axi_rd(12'h100, rd, rresp);
    `CHK(rresp, `DCAC_RESP_ERR, "unmapped read")
    // Each size runs after a soft reset, so a leftover done state cannot mask a fault.
    foreach (sizes[i]) begin
      axi_wr(`DCAC_OFF_MAIN_CTRL, 32'h2);
      repeat (2) @(posedge clk_sys);
      rd_chk(`DCAC_OFF_MAIN_CTRL, 32'h0);
      rd_chk(ch_a(0, `DCAC_CH_MEM_START), 32'h0);
      axi_wr(ch_a(0, `DCAC_CH_MEM_START), 32'h200);
      axi_wr(ch_a(0, `DCAC_CH_MEM_END), 32'h200 + 32'(3 * sizes[i]));
      axi_wr(ch_a(0, `DCAC_CH_CTRL), 32'h1_0000 | (32'(sizes[i]) << 20));
      axi_wr(ch_a(0, `DCAC_CH_IEN), 32'h1);
      axi_wr(ch_a(0, `DCAC_CH_EN), 32'h1);
      want[0] <= 1'b1;
      repeat (20) @(posedge clk_sys);
      `CHK(ch_run[0], 1'b0, "run without block enable")
      rd_chk(ch_a(0, `DCAC_CH_MEM_START), 32'h200);
      axi_wr(`DCAC_OFF_MAIN_CTRL, 32'h1);
      wait_term(0);
      repeat (4) @(posedge clk_sys);
      `CHK(ch_run[0], 1'b0, "run after end")
      `CHK(mem_addr[23:0], 24'h200 + 24'(3 * sizes[i]), "pointer out")
      rd_chk(ch_a(0, `DCAC_CH_MEM_START), 32'h200 + 32'(3 * sizes[i]));
      rd_chk(ch_a(0, `DCAC_CH_ISTAT), 32'h1);
      rd_chk(`DCAC_OFF_PKT_DBG, last_word);
      want[0] <= 1'b0;
    end
    `CHK(irq, 1'b0, "irq while masked")
    axi_wr(`DCAC_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1, "irq unmasked")
    axi_rd(`DCAC_OFF_IRQ_STAT, rd, rresp);
    `CHK(rd[0], 1'b1, "global status")
    // The channel's done bit re-arms the global status until it is cleared itself.
    axi_wr(ch_a(0, `DCAC_CH_ISTAT), 32'h1);
    rd_chk(ch_a(0, `DCAC_CH_ISTAT), 32'h0);
    axi_rd(`DCAC_OFF_IRQ_STAT, rd, rresp);
    `CHK(rd[0], 1'b1, "latched status")
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0, "irq after clear")
    // Fixed pointer equal to the end value must neither stop nor move.
    axi_wr(ch_a(1, `DCAC_CH_MEM_START), 32'h300);
    axi_wr(ch_a(1, `DCAC_CH_MEM_END), 32'hab00_0300);
    rd_chk(ch_a(1, `DCAC_CH_MEM_END), 32'h300);
    axi_wr(ch_a(1, `DCAC_CH_CTRL), 32'h20_0000);
    axi_wr(ch_a(1, `DCAC_CH_EN), 32'h1);
    want[1] <= 1'b1;
    repeat (40) @(posedge clk_sys);
    `CHK(ch_run[1], 1'b1, "fixed channel running")
    `CHK(ch_term[1], 1'b0, "fixed channel ended")
    `CHK(mem_addr[47:24], 24'h300, "fixed pointer out")
    rd_chk(ch_a(1, `DCAC_CH_MEM_START), 32'h300);
    axi_wr(`DCAC_OFF_MAIN_CTRL, 32'h0);
    repeat (4) @(posedge clk_sys);
    `CHK(ch_run[1], 1'b0, "run after block disable")
    finish_test();
  end
endmodule : dcac_top_tb
